// >>> core/clk_rise_detect.v
`timescale 1ns/1ps
`include "trace_xing_defs.vh"
// Finds rising edges of a slow clock sampled on the fast clock
module clk_rise_detect (
  input wire mclk_i,
  input wire reset_i,
  input wire level_i,
  output wire rise_o
);
  reg prev;

  always @(posedge mclk_i) begin
    if (reset_i) begin
      // Track the pin in reset, so no false edge follows release
      prev <= level_i;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
endmodule // clk_rise_detect

// >>> core/sync2.v
`timescale 1ns/1ps
`include "trace_xing_defs.vh"
// Two-stage synchroniser, advancing only on the enable of its domain
module sync2 #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire reset_i,
  input wire en_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] stage1;

  // Stage one feeds stage two only, to keep metastability contained
  always @(posedge mclk_i) begin
    if (reset_i) begin
      stage1 <= {W{`XING_ZERO_BIT}};
      q_o <= {W{`XING_ZERO_BIT}};
    end else if (en_i) begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule // sync2

// >>> core/trace_buffer_clock_crossing.v
`timescale 1ns/1ps
`include "trace_xing_defs.vh"
module trace_buffer_clock_crossing #(
  parameter DATA_W = `XING_DATA_W,
  parameter ADDR_W = `XING_BUS_ADDR_W,
  parameter TAP_AW = `XING_TAP_ADDR_W
) (
  input wire mclk_i,
  input wire reset_i,
  input wire bus_reset_i,
  input wire tap_reset_i,
  input wire hclk_i,
  input wire tck_i,
  input wire sync_bypass_select_i,
  input wire hsel_i,
  input wire hwrite_i,
  input wire [ADDR_W-1:0] haddr_i,
  input wire [DATA_W-1:0] hwdata_i,
  output reg [DATA_W-1:0] bus_read_data_out_o,
  output reg bus_transfer_done_o,
  output reg ram_cs_o,
  output reg ram_we_o,
  output reg register_read_strobe_o,
  output reg register_write_strobe_o,
  output reg [ADDR_W-1:0] core_addr_o,
  output reg [DATA_W-1:0] core_wdata_o,
  input wire [DATA_W-1:0] ram_rdata_i,
  input wire [DATA_W-1:0] reg_rdata_i,
  input wire tap_update_dr_i,
  input wire tap_rw_i,
  input wire [TAP_AW-1:0] tap_register_address_i,
  input wire [DATA_W-1:0] tap_scan_write_data_i,
  output reg tap_reg_read_o,
  output reg tap_reg_write_o,
  output reg [TAP_AW-1:0] tap_addr_o,
  output reg [DATA_W-1:0] tap_wdata_o,
  output reg [DATA_W-1:0] tap_read_data_o,
  output reg tap_busy_o,
  input wire ram_full_i,
  input wire triggered_i,
  input wire acquisition_done_flag_i,
  output reg [`XING_STATUS_W-1:0] tap_status_o
);
  localparam [1:0] B_IDLE = 2'h0;
  localparam [1:0] B_WDATA = 2'h1;
  localparam [1:0] B_WAIT = 2'h2;
  localparam [1:0] B_CLOSE = 2'h3;
  localparam [1:0] C_IDLE = 2'h0;
  localparam [1:0] C_CAP = 2'h1;
  localparam [1:0] C_HOLD = 2'h2;

  // RAM lies in the upper half of the bus window
  function is_ram;
    input [ADDR_W-1:0] a;
    begin
      is_ram = a[ADDR_W-1];
    end
  endfunction

  wire hclk_rise;
  wire tck_rise;
  wire core_side_request;
  wire bus_side_ack;
  wire tap_strobe_core;
  wire tap_ack_tck;
  wire [`XING_STATUS_W-1:0] status_tck;
  wire [`XING_STATUS_W-1:0] status_core;

  reg [1:0] bus_state;
  reg bus_side_request;
  reg latched_write;
  reg [ADDR_W-1:0] latched_bus_address;
  reg [DATA_W-1:0] latched_write_data;
  reg bypass_read_go;
  reg bypass_write_go;
  reg [1:0] core_state;
  reg core_side_ack;
  reg [DATA_W-1:0] core_read_data_reg;
  reg tap_access_strobe;
  reg tap_access_ack;
  reg tap_pending;
  reg tap_write_flag;
  reg [TAP_AW-1:0] tap_register_address;
  reg [DATA_W-1:0] tap_scan_write_data;
  reg [DATA_W-1:0] read_return_mux;

  // Each foreign clock is sampled and its rising edge steps its own logic
  clk_rise_detect u_hclk_rise (
    .mclk_i(mclk_i),
    .reset_i(bus_reset_i),
    .level_i(hclk_i),
    .rise_o(hclk_rise)
  );

  clk_rise_detect u_tck_rise (
    .mclk_i(mclk_i),
    .reset_i(tap_reset_i),
    .level_i(tck_i),
    .rise_o(tck_rise)
  );

  // Bus request into the core domain, two core flops
  sync2 #(.W(1)) u_req_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .en_i(`XING_ONE_BIT),
    .d_i(bus_side_request),
    .q_o(core_side_request)
  );

  // Core ack into the bus domain, two HCLK flops
  sync2 #(.W(1)) u_ack_sync (
    .mclk_i(mclk_i),
    .reset_i(bus_reset_i),
    .en_i(hclk_rise),
    .d_i(core_side_ack),
    .q_o(bus_side_ack)
  );

  // TAP handshake, both directions synchronised
  sync2 #(.W(1)) u_strobe_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .en_i(`XING_ONE_BIT),
    .d_i(tap_access_strobe),
    .q_o(tap_strobe_core)
  );

  sync2 #(.W(1)) u_tap_ack_sync (
    .mclk_i(mclk_i),
    .reset_i(tap_reset_i),
    .en_i(tck_rise),
    .d_i(tap_access_ack),
    .q_o(tap_ack_tck)
  );

  // Status flags registered in the core domain, then synchronised to TCK
  sync2 #(.W(`XING_STATUS_W)) u_status_core (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .en_i(`XING_ONE_BIT),
    .d_i({acquisition_done_flag_i, triggered_i, ram_full_i}),
    .q_o(status_core)
  );

  sync2 #(.W(`XING_STATUS_W)) u_status_tck (
    .mclk_i(mclk_i),
    .reset_i(tap_reset_i),
    .en_i(tck_rise),
    .d_i(status_core),
    .q_o(status_tck)
  );

  // Captured data in handshake mode, live RAM/register data in bypass
  always @* begin
    if (sync_bypass_select_i) begin
      read_return_mux = is_ram(latched_bus_address) ? ram_rdata_i : reg_rdata_i;
    end else begin
      read_return_mux = core_read_data_reg;
    end
  end

  // Bus interface, cleared only by its own reset
  always @(posedge mclk_i) begin
    if (bus_reset_i) begin
      bus_state <= B_IDLE;
      bus_side_request <= `XING_ZERO_BIT;
      latched_write <= `XING_ZERO_BIT;
      latched_bus_address <= {ADDR_W{`XING_ZERO_BIT}};
      latched_write_data <= `XING_ZERO_WORD;
      bus_read_data_out_o <= `XING_ZERO_WORD;
      bus_transfer_done_o <= `XING_ZERO_BIT;
      bypass_read_go <= `XING_ZERO_BIT;
      bypass_write_go <= `XING_ZERO_BIT;
    end else begin
      bypass_read_go <= `XING_ZERO_BIT;
      bypass_write_go <= `XING_ZERO_BIT;
      if (hclk_rise) begin
        bus_transfer_done_o <= `XING_ZERO_BIT;
        case (bus_state)
          B_IDLE: begin
            if (hsel_i) begin
              latched_bus_address <= haddr_i;
              latched_write <= hwrite_i;
              if (hwrite_i) begin
                bus_state <= B_WDATA;
              end else if (sync_bypass_select_i) begin
                bypass_read_go <= `XING_ONE_BIT;
                bus_state <= B_WAIT;
              end else begin
                bus_side_request <= `XING_ONE_BIT;
                bus_state <= B_WAIT;
              end
            end
          end
          B_WDATA: begin
            latched_write_data <= hwdata_i;
            if (sync_bypass_select_i) begin
              bypass_write_go <= `XING_ONE_BIT;
              bus_transfer_done_o <= `XING_ONE_BIT;
              bus_state <= B_IDLE;
            end else begin
              bus_side_request <= `XING_ONE_BIT;
              bus_state <= B_WAIT;
            end
          end
          B_WAIT: begin
            if (sync_bypass_select_i) begin
              bus_read_data_out_o <= read_return_mux;
              bus_transfer_done_o <= `XING_ONE_BIT;
              bus_state <= B_IDLE;
            end else if (bus_side_ack) begin
              if (!latched_write) begin
                bus_read_data_out_o <= read_return_mux;
              end
              bus_transfer_done_o <= `XING_ONE_BIT;
              bus_side_request <= `XING_ZERO_BIT;
              bus_state <= B_CLOSE;
            end
          end
          B_CLOSE: begin
            // Next transfer waits for the bus-side ack to fall
            if (!bus_side_ack) begin
              bus_state <= B_IDLE;
            end
          end
          default: begin
            bus_state <= B_IDLE;
          end
        endcase
      end
    end
  end

  // Core side of the bus crossing, plus TAP access service
  always @(posedge mclk_i) begin
    if (reset_i) begin
      core_state <= C_IDLE;
      core_side_ack <= `XING_ZERO_BIT;
      core_read_data_reg <= `XING_ZERO_WORD;
      ram_cs_o <= `XING_ZERO_BIT;
      ram_we_o <= `XING_ZERO_BIT;
      register_read_strobe_o <= `XING_ZERO_BIT;
      register_write_strobe_o <= `XING_ZERO_BIT;
      core_addr_o <= {ADDR_W{`XING_ZERO_BIT}};
      core_wdata_o <= `XING_ZERO_WORD;
      tap_access_ack <= `XING_ZERO_BIT;
      tap_pending <= `XING_ZERO_BIT;
      tap_reg_read_o <= `XING_ZERO_BIT;
      tap_reg_write_o <= `XING_ZERO_BIT;
      tap_addr_o <= {TAP_AW{`XING_ZERO_BIT}};
      tap_wdata_o <= `XING_ZERO_WORD;
      tap_read_data_o <= `XING_ZERO_WORD;
    end else begin
      ram_cs_o <= `XING_ZERO_BIT;
      ram_we_o <= `XING_ZERO_BIT;
      register_read_strobe_o <= `XING_ZERO_BIT;
      register_write_strobe_o <= `XING_ZERO_BIT;
      tap_reg_read_o <= `XING_ZERO_BIT;
      tap_reg_write_o <= `XING_ZERO_BIT;
      core_addr_o <= latched_bus_address;
      core_wdata_o <= latched_write_data;
      if (bypass_read_go || bypass_write_go) begin
        // Bypass: one strobe cycle, no request/ack handshake
        ram_cs_o <= is_ram(latched_bus_address);
        ram_we_o <= bypass_write_go & is_ram(latched_bus_address);
        register_read_strobe_o <= bypass_read_go & ~is_ram(latched_bus_address);
        register_write_strobe_o <= bypass_write_go & ~is_ram(latched_bus_address);
      end
      case (core_state)
        C_IDLE: begin
          if (core_side_request && !core_side_ack) begin
            ram_cs_o <= is_ram(latched_bus_address);
            ram_we_o <= latched_write & is_ram(latched_bus_address);
            register_read_strobe_o <= ~latched_write & ~is_ram(latched_bus_address);
            register_write_strobe_o <= latched_write & ~is_ram(latched_bus_address);
            core_state <= C_CAP;
          end
        end
        C_CAP: begin
          if (!latched_write) begin
            core_read_data_reg <= is_ram(latched_bus_address) ? ram_rdata_i : reg_rdata_i;
          end
          core_side_ack <= `XING_ONE_BIT;
          core_state <= C_HOLD;
        end
        C_HOLD: begin
          if (!core_side_request) begin
            core_side_ack <= `XING_ZERO_BIT;
            core_state <= C_IDLE;
          end
        end
        default: begin
          core_state <= C_IDLE;
        end
      endcase
      // TAP fields sampled only once the synchronised strobe is seen
      if (tap_strobe_core && !tap_access_ack && !tap_pending) begin
        tap_reg_read_o <= ~tap_write_flag;
        tap_reg_write_o <= tap_write_flag;
        tap_addr_o <= tap_register_address;
        tap_wdata_o <= tap_scan_write_data;
        tap_pending <= `XING_ONE_BIT;
      end else if (tap_pending) begin
        if (!tap_write_flag) begin
          tap_read_data_o <= reg_rdata_i;
        end
        tap_pending <= `XING_ZERO_BIT;
        tap_access_ack <= `XING_ONE_BIT;
      end else if (!tap_strobe_core) begin
        tap_access_ack <= `XING_ZERO_BIT;
      end
    end
  end

  // TAP-domain logic, stepped on TCK edges and cleared by the TAP reset
  always @(posedge mclk_i) begin
    if (tap_reset_i) begin
      tap_access_strobe <= `XING_ZERO_BIT;
      tap_write_flag <= `XING_ZERO_BIT;
      tap_register_address <= {TAP_AW{`XING_ZERO_BIT}};
      tap_scan_write_data <= `XING_ZERO_WORD;
      tap_status_o <= `XING_ZERO_STATUS;
      tap_busy_o <= `XING_ZERO_BIT;
    end else if (tck_rise) begin
      tap_status_o <= status_tck;
      // Busy from the accepting edge, so it covers the core pulse
      tap_busy_o <= tap_update_dr_i | tap_access_strobe | tap_ack_tck;
      // Update-DR while a previous access is in flight is dropped
      if (tap_update_dr_i && !tap_access_strobe && !tap_ack_tck) begin
        tap_write_flag <= tap_rw_i;
        tap_register_address <= tap_register_address_i;
        tap_scan_write_data <= tap_scan_write_data_i;
        tap_access_strobe <= `XING_ONE_BIT;
      end else if (tap_access_strobe && tap_ack_tck) begin
        tap_access_strobe <= `XING_ZERO_BIT;
      end
    end
  end
endmodule // trace_buffer_clock_crossing

// >>> core/trace_xing_defs.vh
`ifndef TRACE_XING_DEFS_VH
`define TRACE_XING_DEFS_VH

// Reset values, plus the set value XING_ONE_BIT
`define XING_ZERO_BIT 1'b0
`define XING_ONE_BIT 1'b1
`define XING_ZERO_WORD 32'h00000000
`define XING_ZERO_STATUS 3'h0

// Default widths
`define XING_DATA_W 32
`define XING_BUS_ADDR_W 10
`define XING_TAP_ADDR_W 7
`define XING_STATUS_W 3

// Status flag positions in the status vectors
`define XING_STAT_FULL 0
`define XING_STAT_TRIG 1
`define XING_STAT_DONE 2

`endif

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0;
  logic rst = 1'b1;
  logic brst = 1'b0;
  logic clr = 1'b0;
  logic byp = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic upd = 1'b0;
  logic trw = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] twdata = 32'h0;
  logic [6:0] taddr = 7'h00;
  logic [2:0] stat = 3'h0;
  logic [5:0] seen = 6'h00;
  logic [9:0] seen_a;
  logic [6:0] seen_ta;
  logic [31:0] seen_wd;
  wire hclk, tck, done, cs, we, rs, ws, trs, tws, busy;
  wire [31:0] rdo, ramd, regd, cwd, twd, trd;
  wire [9:0] ca;
  wire [6:0] ta;
  wire [2:0] tst;
  int n_fail = 0;
  int checks_done = 0;

  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (clr)
      seen <= 6'h00;
    else if (cs | rs | ws | trs | tws)
      seen <= seen | {tws, trs, ws, rs, we, cs};
    if (cs | rs | ws) begin
      seen_a <= ca;
      seen_wd <= cwd;
    end
    if (trs | tws)
      seen_ta <= ta;
  end

  trace_buffer_clock_crossing dut_u (
    .mclk_i(mclk_i), .reset_i(rst), .bus_reset_i(rst | brst), .tap_reset_i(rst), .hclk_i(hclk),
    .tck_i(tck), .sync_bypass_select_i(byp), .hsel_i(hsel), .hwrite_i(hwrite), .haddr_i(haddr),
    .hwdata_i(hwdata), .bus_read_data_out_o(rdo), .bus_transfer_done_o(done), .ram_cs_o(cs),
    .ram_we_o(we), .register_read_strobe_o(rs), .register_write_strobe_o(ws),
    .core_addr_o(ca), .core_wdata_o(cwd), .ram_rdata_i(ramd), .reg_rdata_i(regd),
    .tap_update_dr_i(upd), .tap_rw_i(trw), .tap_register_address_i(taddr),
    .tap_scan_write_data_i(twdata), .tap_reg_read_o(trs), .tap_reg_write_o(tws),
    .tap_addr_o(ta), .tap_wdata_o(twd), .tap_read_data_o(trd), .tap_busy_o(busy),
    .ram_full_i(stat[0]), .triggered_i(stat[1]), .acquisition_done_flag_i(stat[2]),
    .tap_status_o(tst));
  xing_far_side far_u (
    .mclk_i(mclk_i), .cs_i(cs), .we_i(we), .rd_i(rs), .trd_i(trs), .addr_i(ca),
    .taddr_i(ta), .hclk_o(hclk), .tck_o(tck), .ram_o(ramd), .reg_o(regd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Address bit 9 picks memory, otherwise registers
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    int hi;
    clr = 1'b1;
    @(posedge mclk_i) #1;
    clr = 1'b0;
    @(posedge hclk);
    hsel = 1'b1;
    hwrite = w;
    haddr = a;
    @(posedge hclk);
    hsel = 1'b0;
    hwdata = d;
    for (i = 0; i < 400 && done !== 1'b1; i++)
      @(posedge mclk_i) #1;
    if (i == 400) begin
      n_fail++;
      close_out();
    end
    for (hi = 0; hi < 20 && done === 1'b1; hi++)
      @(posedge mclk_i) #1;
    check(32'(hi), 32'h6);
    check({26'h0, seen}, w ? (a[9] ? 32'h3 : 32'h8) : (a[9] ? 32'h1 : 32'h4));
    check({22'h0, seen_a}, {22'h0, a});
    if (w)
      check(seen_wd, d);
    else
      check(rdo, a[9] ? {22'h3037a, a} : {22'h17a4c, a});
    // Let the request and both acks fall before the next select
    repeat (4) @(posedge hclk);
  endtask

  task automatic tap(input logic w, input logic [6:0] a, input logic [31:0] d);
    int i;
    clr = 1'b1;
    @(posedge mclk_i) #1;
    clr = 1'b0;
    @(posedge tck);
    upd = 1'b1;
    trw = w;
    taddr = a;
    twdata = d;
    @(posedge tck);
    upd = 1'b0;
    for (i = 0; i < 400 && (busy !== 1'b0 || seen[5:4] == 2'b00); i++)
      @(posedge mclk_i) #1;
    if (i == 400) begin
      n_fail++;
      close_out();
    end
    check({30'h0, seen[5:4]}, {30'h0, w, !w});
    check({25'h0, seen_ta}, {25'h0, a});
    if (!w)
      check(trd, {25'h0a5b3c1, a});
  endtask

  task automatic t_async;
    bus(1'b1, 10'h3ff, 32'hdeadbeef);
    bus(1'b0, 10'h200, 32'h0);
    bus(1'b1, 10'h000, 32'h12345678);
    bus(1'b0, 10'h1ff, 32'h0);
  endtask

  task automatic t_bypass;
    byp = 1'b1;
    bus(1'b0, 10'h3ff, 32'h0);
    bus(1'b1, 10'h1ff, 32'h0f0f5a5a);
    bus(1'b0, 10'h000, 32'h0);
    byp = 1'b0;
  endtask

  // Only idle registers are read over the TAP, never live pointers
  task automatic t_tap;
    tap(1'b1, 7'h7f, 32'ha5a55a5a);
    tap(1'b0, 7'h7f, 32'h0);
    byp = 1'b1;
    tap(1'b0, 7'h00, 32'h0);
    byp = 1'b0;
  endtask

  task automatic t_status;
    for (int k = 0; k < 8; k++) begin
      stat = 3'(k);
      repeat (6) @(posedge tck);
      check({29'h0, tst}, {29'h0, stat});
    end
  endtask

  // Bus reset alone clears the bus side and leaves TAP read data standing
  task automatic t_bus_reset;
    @(posedge mclk_i) #1;
    brst = 1'b1;
    repeat (2) @(posedge mclk_i) #1;
    check(rdo, 32'h0);
    check(trd, {25'h0a5b3c1, 7'h00});
    brst = 1'b0;
    repeat (2) @(posedge mclk_i) #1;
    bus(1'b0, 10'h155, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    t_async();
    t_bypass();
    t_tap();
    t_bus_reset();
    t_status();
    close_out();
  end
endmodule // tb_top

// >>> verif/xing_checker.sv
`timescale 1ns/1ps
module xing_checker #(
  parameter DATA_W = 32,
  parameter ADDR_W = 10,
  parameter TAP_AW = 7
) (
  input wire mclk_i,
  input wire reset_i,
  input wire bus_reset_i,
  input wire tap_reset_i,
  input wire sync_bypass_select_i,
  input wire [DATA_W-1:0] tap_scan_write_data_i,
  input wire bus_transfer_done_o,
  input wire ram_cs_o,
  input wire ram_we_o,
  input wire register_read_strobe_o,
  input wire register_write_strobe_o,
  input wire tap_reg_read_o,
  input wire tap_reg_write_o,
  input wire [DATA_W-1:0] tap_wdata_o,
  input wire tap_busy_o
);
  wire any_rst = reset_i | bus_reset_i | tap_reset_i;
  reg [7:0] since;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (any_rst);
  // Cycles since the last core strobe, parked at ff when none
  always @(posedge mclk_i) begin
    if (any_rst)
      since <= 8'hff;
    else if (ram_cs_o | register_read_strobe_o | register_write_strobe_o)
      since <= 8'h00;
    else if (since != 8'hff)
      since <= since + 8'h01;
  end
  a_cs_one_cycle: assert property (ram_cs_o |=> !ram_cs_o)
    else $error("chip select held too long");
  a_rd_one_cycle: assert property (register_read_strobe_o |=> !register_read_strobe_o)
    else $error("read strobe held too long");
  a_wr_one_cycle: assert property (register_write_strobe_o |=> !register_write_strobe_o)
    else $error("write strobe held too long");
  a_we_with_cs: assert property (ram_we_o |-> ram_cs_o)
    else $error("write enable without chip select");
  a_done_after_strobe: assert property ($rose(bus_transfer_done_o) && !sync_bypass_select_i
    |-> since >= 8'd3 && since <= 8'd100)
    else $error("transfer done not tied to a core access");
  a_tap_pulse_once: assert property (tap_reg_write_o || tap_reg_read_o
    |=> !tap_reg_write_o && !tap_reg_read_o)
    else $error("tap access pulse too long");
  a_tap_rw_apart: assert property (!(tap_reg_read_o && tap_reg_write_o))
    else $error("tap read and write together");
  a_tap_wdata_held: assert property (tap_reg_write_o |-> tap_wdata_o == tap_scan_write_data_i)
    else $error("tap write data differs from scan data");
  a_tap_busy_span: assert property (tap_reg_write_o || tap_reg_read_o |-> tap_busy_o)
    else $error("tap access outside busy");
endmodule // xing_checker

bind trace_buffer_clock_crossing xing_checker #(
  .DATA_W(DATA_W), .ADDR_W(ADDR_W), .TAP_AW(TAP_AW)) chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .bus_reset_i(bus_reset_i), .tap_reset_i(tap_reset_i),
  .sync_bypass_select_i(sync_bypass_select_i), .tap_scan_write_data_i(tap_scan_write_data_i),
  .bus_transfer_done_o(bus_transfer_done_o), .ram_cs_o(ram_cs_o), .ram_we_o(ram_we_o),
  .register_read_strobe_o(register_read_strobe_o),
  .register_write_strobe_o(register_write_strobe_o), .tap_reg_read_o(tap_reg_read_o),
  .tap_reg_write_o(tap_reg_write_o), .tap_wdata_o(tap_wdata_o), .tap_busy_o(tap_busy_o));

// >>> verif/xing_far_side.sv
`timescale 1ns/1ps
module xing_far_side (
  input wire mclk_i,
  input wire cs_i,
  input wire we_i,
  input wire rd_i,
  input wire trd_i,
  input wire [9:0] addr_i,
  input wire [6:0] taddr_i,
  output logic hclk_o = 1'b0,
  output logic tck_o = 1'b0,
  output logic [31:0] ram_o,
  output logic [31:0] reg_o
);
  int hc = 0;
  int tc = 0;
  logic [31:0] ram_q = 32'h0;
  logic [31:0] reg_q = 32'h0;
  // Read data stands during the strobe cycle, then holds until the next read
  assign ram_o = (cs_i && !we_i) ? {22'h3037a, addr_i} : ram_q;
  assign reg_o = trd_i ? {25'h0a5b3c1, taddr_i} : (rd_i ? {22'h17a4c, addr_i} : reg_q);
  always @(posedge mclk_i) begin
    hc <= (hc == 5) ? 0 : hc + 1;
    tc <= (tc == 7) ? 0 : tc + 1;
    // Free-running, both well below the core rate
    hclk_o <= #1 (hc < 3);
    tck_o <= #1 (tc < 4);
    if (cs_i && !we_i)
      ram_q <= ram_o;
    if (trd_i || rd_i)
      reg_q <= reg_o;
  end
endmodule // xing_far_side
